// ===== core/rfp_map.svh
`ifndef RFP_MAP_SVH
`define RFP_MAP_SVH
// Clock and timer base
`define RFP_CLK_HZ        25000000
`define RFP_TICK_MS       1
// Rated continuous current in measurement counts
`define RFP_RATED_CUR     16'd1000
// Level thresholds in half multiples of the rated current
`define RFP_L1_MULT2      5'd4
`define RFP_L2_MULT2      5'd5
`define RFP_L3_MULT2      5'd6
`define RFP_L4_MULT2      5'd8
`define RFP_L5_MULT2      5'd10
`define RFP_L6_MULT2      5'd12
`define RFP_SC_MULT2      5'd14
// Level persistence delays in ms
`define RFP_L1_DLY_MS     16'd60000
`define RFP_L2_DLY_MS     16'd10000
`define RFP_L3_DLY_MS     16'd1000
`define RFP_L4_DLY_MS     16'd20
`define RFP_L5_DLY_MS     16'd4
`define RFP_L6_DLY_MS     16'd2
// Short circuit: total response limit and glitch filter
`define RFP_SC_MAX_US     1000
`define RFP_SC_FILT_CYC   3'd4
// Lockout after a current trip, in ms
`define RFP_LOCK_MS       14'd10000
// Temperature thresholds in degrees C
`define RFP_OT_SET_C      9'sd135
`define RFP_OT_CLR_C      9'sd130
// Indicator blink step in ms
`define RFP_BLINK_MS      8'd250
// Indicator flash counts
`define RFP_OT_FLASHES    5'd8
`endif

// ===== core/rfp_pkg.sv
package rfp_pkg;
  typedef enum logic [1:0] {RFP_RUN, RFP_LOCK, RFP_ARMED} rfp_trip_t;
  typedef logic signed [15:0] rfp_cur_t;
  typedef logic signed [8:0]  rfp_temp_t;
endpackage

// ===== core/rfp_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "rfp_map.svh"

// How it works
// R1: six over-current levels plus short circuit
// R2: one-way acts on source-to-load only
// R3: fixed level multiples and delays
// R4: short circuit trips within 1 ms
// R5: detection adds under 2 ms
// R6: level fires after full continuous delay only
// R7: trip opens switch and blinks level
// R8: thresholds are constants, not user settable
// R9: 10 s lockout, then trigger toggle
// R10: 135 C opens switch, blinks pattern
// R11: leave over-temperature below 130 C
// R12: triggers and voltage tracked during over-temperature
// R13: on exit follow present main trigger
// R14: under-voltage during over-temperature keeps switch open
// R15: switch opens on trigger or fault
// R16: override closes switch under under-voltage
// R17: indicator shows highest priority fault
// R18: no fault: switch follows main trigger
// R19: level timer restarts when current drops
module rfp_guard #(
  parameter int TICK_CYC = `RFP_CLK_HZ / 1000 * `RFP_TICK_MS
) (
  input  wire logic             clk,           // 25 MHz clock
  input  wire logic             rstn,          // Sync reset, active low
  input  wire rfp_pkg::rfp_cur_t  cur_meas,    // Switch current, + = to load
  input  wire rfp_pkg::rfp_temp_t temp_meas,   // Internal temperature, C
  input  wire logic             uv_active,     // Under-voltage detected
  input  wire logic             uv_enable,     // Under-voltage feature on
  input  wire logic             main_trig_pin, // Main trigger pin
  input  wire logic             ovr_trig_pin,  // Override trigger pin
  input  wire logic             bidir_pin,     // Two-direction variant strap
  output var  logic             gate_q,        // Switch closed when high
  output var  logic             fault_led_q,   // Red fault indicator
  output var  logic [2:0]       trip_level_q   // 0 none, 1-6 level, 7 short
);
  localparam logic [4:0]  MULT2 [7] = '{`RFP_L1_MULT2, `RFP_L2_MULT2,
    `RFP_L3_MULT2, `RFP_L4_MULT2, `RFP_L5_MULT2, `RFP_L6_MULT2,
    `RFP_SC_MULT2};
  localparam logic [15:0] DLY [6] = '{`RFP_L1_DLY_MS, `RFP_L2_DLY_MS,
    `RFP_L3_DLY_MS, `RFP_L4_DLY_MS, `RFP_L5_DLY_MS, `RFP_L6_DLY_MS};

  // Pin synchronisers
  logic main_s1, main_s2, main_s3, ovr_s1, ovr_s2, bidir_s1, bidir_s2;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      main_s1  <= 1'b0;
      main_s2  <= 1'b0;
      main_s3  <= 1'b0;
      ovr_s1   <= 1'b0;
      ovr_s2   <= 1'b0;
      bidir_s1 <= 1'b0;
      bidir_s2 <= 1'b0;
    end else begin
      main_s1  <= main_trig_pin;
      main_s2  <= main_s1;
      main_s3  <= main_s2;
      ovr_s1   <= ovr_trig_pin;
      ovr_s2   <= ovr_s1;
      bidir_s1 <= bidir_pin;
      bidir_s2 <= bidir_s1;
    end
  end

  // Millisecond tick
  logic [14:0] div_q, div_d;
  logic        tick_q, tick_d;
  always_comb begin
    tick_d = (div_q == 15'(TICK_CYC - 1));
    div_d  = tick_d ? 15'h0 : div_q + 15'h1;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_q  <= 15'h0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // Current magnitude in the protected direction
  logic [15:0] mag;
  logic [6:0]  over;
  always_comb begin
    if (cur_meas >= 0) begin
      mag = 16'(cur_meas);
    end else if (bidir_s2) begin
      mag = 16'(-cur_meas);                                  // [R2]
    end else begin
      mag = 16'h0;                                           // [R2]
    end
  end

  // Per-level persistence timers
  logic [5:0]  lvl_exp;
  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_cmp
      assign over[i] = {4'h0, mag, 1'b0} >
                       21'(`RFP_RATED_CUR) * 21'(MULT2[i]);  // [R3] [R8]
    end
    for (i = 0; i < 6; i++) begin : g_lvl
      logic [15:0] cnt_q, cnt_d;
      always_comb begin
        if (!over[i]) begin
          cnt_d = 16'h0;                                     // [R19]
        end else if (tick_q && cnt_q != DLY[i] + 16'h1) begin
          cnt_d = cnt_q + 16'h1;                             // [R5]
        end else begin
          cnt_d = cnt_q;
        end
      end
      always_ff @(posedge clk) begin
        if (!rstn) begin
          cnt_q <= 16'h0;
        end else begin
          cnt_q <= cnt_d;
        end
      end
      // One tick beyond the delay, as the first tick may come at once
      assign lvl_exp[i] = over[i] && cnt_q == DLY[i] + 16'h1; // [R6] [R1]
      a_lvl_restart: assert property (@(posedge clk)  // [R19]
        disable iff (!rstn) !over[i] |=> cnt_q == 16'h0)
        else $error("level timer kept running below threshold");
    end
  endgenerate

  // Short-circuit filter
  logic [2:0] sc_cnt_q, sc_cnt_d;
  logic       sc_exp;
  always_comb begin
    if (!over[6]) begin
      sc_cnt_d = 3'h0;
    end else if (sc_cnt_q != `RFP_SC_FILT_CYC - 3'h1) begin
      sc_cnt_d = sc_cnt_q + 3'h1;
    end else begin
      sc_cnt_d = sc_cnt_q;
    end
    sc_exp = over[6] && sc_cnt_q == `RFP_SC_FILT_CYC - 3'h1; // [R4]
  end

  // Trip, lockout and re-arm
  rfp_pkg::rfp_trip_t state_q, state_d;
  logic [13:0] lock_q, lock_d;
  logic [2:0]  level_d;
  always_comb begin
    state_d = state_q;
    lock_d  = lock_q;
    level_d = trip_level_q;
    case (state_q)
      rfp_pkg::RFP_RUN: begin
        lock_d = 14'h0;
        if (sc_exp) begin
          level_d = 3'd7;                                    // [R4]
          state_d = rfp_pkg::RFP_LOCK;
        end else if (lvl_exp != 6'h0) begin                  // [R6]
          state_d = rfp_pkg::RFP_LOCK;
          for (int k = 0; k < 6; k++) begin
            if (lvl_exp[k]) begin
              level_d = 3'(k + 1);
            end
          end
        end
      end
      rfp_pkg::RFP_LOCK: begin
        if (tick_q) begin
          lock_d = lock_q + 14'h1;
          if (lock_q == `RFP_LOCK_MS) begin
            state_d = rfp_pkg::RFP_ARMED;                    // [R9]
          end
        end
      end
      rfp_pkg::RFP_ARMED: begin
        if (main_s2 && !main_s3) begin
          state_d = rfp_pkg::RFP_RUN;                        // [R9]
          level_d = 3'd0;
        end
      end
      default: begin
        state_d = rfp_pkg::RFP_RUN;
      end
    endcase
  end

  // Over-temperature, under-voltage hold and switch command
  logic ot_q, ot_d, uv_hold_q, uv_hold_d, uv_eff, gate_d;
  always_comb begin
    ot_d = ot_q;
    if (temp_meas >= `RFP_OT_SET_C) begin
      ot_d = 1'b1;                                           // [R10]
    end else if (temp_meas < `RFP_OT_CLR_C) begin
      ot_d = 1'b0;                                           // [R11]
    end
    uv_hold_d = uv_hold_q;
    if (ot_q && uv_enable && uv_active) begin
      uv_hold_d = 1'b1;                                      // [R12] [R14]
    end else if (!main_s2) begin
      uv_hold_d = 1'b0;
    end
    uv_eff = (uv_enable && uv_active) || uv_hold_q;
    gate_d = main_s2 && state_d == rfp_pkg::RFP_RUN && !ot_d   // [R15] [R18]
             && (!uv_eff || ovr_s2);                       // [R13] [R16]
  end

  // Fault indicator: flash count per fault, steady for under-voltage
  logic [7:0] blk_q, blk_d;
  logic [4:0] ph_q, ph_d, code;
  logic       led_d;
  always_comb begin
    blk_d = blk_q;
    ph_d  = ph_q;
    if (tick_q) begin
      blk_d = (blk_q == `RFP_BLINK_MS - 8'h1) ? 8'h0 : blk_q + 8'h1;
      if (blk_q == `RFP_BLINK_MS - 8'h1) begin
        ph_d = ph_q + 5'h1;
      end
    end
    if (trip_level_q != 3'd0) begin
      code = {2'b00, trip_level_q};                          // [R7] [R17]
    end else if (ot_q) begin
      code = `RFP_OT_FLASHES;                                // [R10] [R17]
    end else begin
      code = 5'h0;
    end
    if (code != 5'h0) begin
      led_d = !ph_q[0] && {1'b0, ph_q[4:1]} < code;
    end else begin
      led_d = uv_eff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sc_cnt_q     <= 3'h0;
      state_q      <= rfp_pkg::RFP_RUN;
      lock_q       <= 14'h0;
      trip_level_q <= 3'd0;
      ot_q         <= 1'b0;
      uv_hold_q    <= 1'b0;
      gate_q       <= 1'b0;
      blk_q        <= 8'h0;
      ph_q         <= 5'h0;
      fault_led_q  <= 1'b0;
    end else begin
      sc_cnt_q     <= sc_cnt_d;
      state_q      <= state_d;
      lock_q       <= lock_d;
      trip_level_q <= level_d;
      ot_q         <= ot_d;
      uv_hold_q    <= uv_hold_d;
      gate_q       <= gate_d;
      blk_q        <= blk_d;
      ph_q         <= ph_d;
      fault_led_q  <= led_d;
    end
  end

  a_trip_gate_open: assert property (@(posedge clk) disable iff (!rstn) // [R7]
    state_q != rfp_pkg::RFP_RUN |-> !gate_q)
    else $error("switch closed while tripped");
  a_ot_gate_open: assert property (@(posedge clk) disable iff (!rstn) // [R10]
    ot_q |-> !gate_q)
    else $error("switch closed in over-temperature");
  a_ot_hyst_hold: assert property (@(posedge clk) disable iff (!rstn) // [R11]
    ot_q && temp_meas >= `RFP_OT_CLR_C |=> ot_q)
    else $error("over-temperature left above clear level");
  a_sc_fast_trip: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    (over[6] && state_q == rfp_pkg::RFP_RUN)[*4]
      |=> state_q == rfp_pkg::RFP_LOCK && trip_level_q == 3'd7)
    else $error("short circuit not tripped in time");
  a_sc_filter_min: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    state_q == rfp_pkg::RFP_RUN && !$past(over[6], 3)
      |=> trip_level_q != 3'd7)
    else $error("short circuit tripped before filter time");
  a_lock_no_rearm: assert property (@(posedge clk) disable iff (!rstn) // [R9]
    state_q == rfp_pkg::RFP_LOCK && lock_q < `RFP_LOCK_MS
      |=> state_q == rfp_pkg::RFP_LOCK)
    else $error("lockout ended early");
  a_follow_main: assert property (@(posedge clk) disable iff (!rstn) // [R18]
    state_d == rfp_pkg::RFP_RUN && !ot_d && !uv_eff
      |=> gate_q == $past(main_s2))
    else $error("switch does not follow main trigger");
  a_uv_no_ovr: assert property (@(posedge clk) disable iff (!rstn) // [R16]
    uv_eff && !ovr_s2 |=> !gate_q)
    else $error("switch closed under under-voltage without override");
  a_uv_hold_keep: assert property (@(posedge clk) disable iff (!rstn) // [R14]
    $fell(ot_q) && uv_hold_q && !ovr_s2 |=> !gate_q)
    else $error("switch closed after over-temperature despite under-voltage");
endmodule
`default_nettype wire

// ===== sim/rfp_load_model.sv
`timescale 1ns/1ps
`default_nettype none
// Source and load: current flows only while the switch is closed
module rfp_load_model (
  input  wire logic              clk,      // System clock
  input  wire logic              gate_q,   // Switch command from the guard
  input  wire rfp_pkg::rfp_cur_t load_cur, // Current drawn when closed
  output var  rfp_pkg::rfp_cur_t cur_meas  // Measured switch current
);
  initial cur_meas = '0;
  always @(posedge clk) begin
    cur_meas <= gate_q ? load_cur : '0;
  end
endmodule
`default_nettype wire

// ===== sim/rfp_testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0d got %0d", n, e, g); end end
module testbench;
  localparam int T = 2;
  localparam int RATED = 1000;
  localparam int LIMIT = 90000;
  logic clk, rstn, uv_active, uv_enable, main_trig_pin, ovr_trig_pin;
  logic bidir_pin, gate_q, fault_led_q, led_seen;
  logic [2:0] trip_level_q;
  rfp_pkg::rfp_cur_t load_cur, cur_meas;
  rfp_pkg::rfp_temp_t temp_meas;
  int error_cnt, num_checks, cyc;

  rfp_guard #(.TICK_CYC(T)) uut (.clk(clk), .rstn(rstn), .cur_meas(cur_meas),
    .temp_meas(temp_meas), .uv_active(uv_active), .uv_enable(uv_enable),
    .main_trig_pin(main_trig_pin), .ovr_trig_pin(ovr_trig_pin),
    .bidir_pin(bidir_pin), .gate_q(gate_q), .fault_led_q(fault_led_q),
    .trip_level_q(trip_level_q));
  rfp_load_model load (.clk(clk), .gate_q(gate_q), .load_cur(load_cur),
    .cur_meas(cur_meas));

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic set_main(input logic v);
    @(posedge clk) main_trig_pin <= v;
    step(6);
  endtask

  task automatic wait_trip(input int lim);
    for (int i = 0; i < lim && trip_level_q === 3'h0; i++) step(1);
  endtask

  // Lockout: toggles are ignored, then a toggle re-arms
  task automatic rearm;
    @(posedge clk) load_cur <= '0;
    step(10000 * T / 2);
    set_main(1'b0);
    set_main(1'b1);
    `CHK("gate in lockout", 1'b0, gate_q)
    step(10000 * T / 2 + 100);
    `CHK("led blinked", 1'b1, led_seen)
    set_main(1'b0);
    set_main(1'b1);
    `CHK("gate rearmed", 1'b1, gate_q)
    `CHK("level cleared", 3'h0, trip_level_q)
  endtask

  task automatic t_main;
    set_main(1'b1);
    `CHK("main closes", 1'b1, gate_q)
    set_main(1'b0);
    `CHK("main opens", 1'b0, gate_q)
    set_main(1'b1);
  endtask

  task automatic t_level(input int lvl, input int mult2, input int dly,
                         input bit glitch);
    @(posedge clk) led_seen <= 1'b0;
    load_cur <= rfp_pkg::rfp_cur_t'(RATED * mult2 / 2 + 1);
    if (glitch) begin
      step(15 * T);
      @(posedge clk) load_cur <= rfp_pkg::rfp_cur_t'(RATED);
      step(2);
      @(posedge clk) load_cur <= rfp_pkg::rfp_cur_t'(RATED * mult2 / 2 + 1);
    end
    step(dly * T);
    `CHK("no early trip", 3'h0, trip_level_q)
    `CHK("gate held", 1'b1, gate_q)
    wait_trip(2 * T + 1);
    `CHK("trip level", 3'(lvl), trip_level_q)
    `CHK("gate opened", 1'b0, gate_q)
    rearm();
  endtask

  task automatic t_short;
    @(posedge clk) led_seen <= 1'b0;
    load_cur <= rfp_pkg::rfp_cur_t'(-(RATED * 7 + 1));
    step(50);
    `CHK("one-way ignores reverse", 3'h0, trip_level_q)
    @(posedge clk) bidir_pin <= 1'b1;
    wait_trip(12);
    `CHK("short level", 3'h7, trip_level_q)
    `CHK("short gate", 1'b0, gate_q)
    rearm();
  endtask

  task automatic t_temp;
    @(posedge clk) led_seen <= 1'b0;
    temp_meas <= 9'sd135;
    step(3);
    `CHK("ot gate", 1'b0, gate_q)
    set_main(1'b0);
    step(9000);
    `CHK("ot led", 1'b1, led_seen)
    @(posedge clk) temp_meas <= 9'sd132;
    step(5);
    set_main(1'b1);
    `CHK("ot hysteresis", 1'b0, gate_q)
    set_main(1'b0);
    @(posedge clk) temp_meas <= 9'sd129;
    step(3);
    `CHK("ot exit follows main", 1'b0, gate_q)
    set_main(1'b1);
    `CHK("main after ot", 1'b1, gate_q)
    @(posedge clk) temp_meas <= 9'sd135;
    step(3);
    @(posedge clk) uv_active <= 1'b1;
    step(3);
    @(posedge clk) temp_meas <= 9'sd25;
    uv_active <= 1'b0;
    step(3);
    `CHK("uv holds open", 1'b0, gate_q)
    @(posedge clk) ovr_trig_pin <= 1'b1;
    step(6);
    `CHK("override closes", 1'b1, gate_q)
    @(posedge clk) ovr_trig_pin <= 1'b0;
    step(6);
    `CHK("uv hold after override", 1'b0, gate_q)
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fault_led_q === 1'b1) led_seen <= 1'b1;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("MISMATCH timeout exp %0d got %0d", LIMIT, cyc);
      print_verdict();
    end
  end

  initial begin
    {rstn, uv_active, main_trig_pin, ovr_trig_pin, bidir_pin} = '0;
    uv_enable = 1'b1;
    load_cur = '0;
    temp_meas = 9'sd25;
    {error_cnt, num_checks, cyc} = '0;
    led_seen = 1'b0;
    step(16);
    `CHK("reset gate", 1'b0, gate_q)
    `CHK("reset level", 3'h0, trip_level_q)
    @(posedge clk) rstn <= 1'b1;
    t_main();
    t_level(6, 12, 2, 1'b0);
    t_level(4, 8, 20, 1'b1);
    t_short();
    t_temp();
    print_verdict();
  end
endmodule
`default_nettype wire
